/* File: hw/fps_sequencer.sv */
// Function
// R1: Unlock: dummy write, data-equals-address write, 10us.
// R2: Register load configures only, never starts pulse.
// R3: Bit 0 enables program or erase.
// R4: Bit 1 selects erase over program.
// R5: Bits 6:5 pick pulse width, 01 102.4us.
// R6: Bit 7 selects doubleword over word.
// R7: Bit 15 holds writing mode.
// R8: Bit 4 reads supply margin good.
// R9: Two same-address writes program doubleword.
// R10: Bit 2 busy during pulse.
// R11: Pulse end enters verify mode automatically.
// R12: Supply fault flag set if margin lost.
// R13: Software verify read: two reads, 4us apart.
// R14: Software verifies upper word at plus two.
// R15: Software limits retries to 2.5ms total.
// R16: Clearing write enable enters non-verify mode.
// R17: Clearing hold bit returns to standard mode.
// R18: Control register only as whole 16-bit word.
// R19: Software reaches flash indirectly in writing mode.
// R20: No program or erase under read protection.
// R21: Single word write starts programming immediately.
// R22: Busy clears when pulse counter expires.
`default_nettype none

module fps_sequencer #(
    parameter int unsigned PULSE2_CYCLES = fps_pkg::PULSE2_CYCLES,
    parameter int unsigned PULSE3_CYCLES = fps_pkg::PULSE3_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Control register port
    input wire logic ctrl_wr,
    input wire logic ctrl_word,
    input wire logic [15:0] ctrl_wdata,
    output logic [15:0] ctrl_rdata,
    // Flash write port
    input wire logic flash_wr,
    input wire logic [15:0] flash_addr,
    input wire logic [15:0] flash_wdata,
    // Supply and protection
    input wire logic vpp_in,
    input wire logic read_protect,
    // Cell array side
    output logic pulse_active,
    output logic pulse_erase,
    output logic pulse_dword,
    output logic [15:0] pulse_addr,
    output logic [31:0] pulse_data,
    output logic writing_mode,
    output logic verify_mode
);

    fps_pkg::fps_state_t state;
    fps_pkg::fps_state_t next_state;
    logic [15:0] ctrl_cfg;
    logic [7:0] settle_cnt;
    logic fault;
    logic vs1;
    logic vs2;
    logic vs3;
    logic vpp_ok;
    logic timer_running;
    logic timer_done;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire we = ctrl_cfg[fps_pkg::BIT_WE];
    wire erase_sel = ctrl_cfg[fps_pkg::BIT_ERASE];
    wire dword_sel = ctrl_cfg[fps_pkg::BIT_WIDTH];
    wire [1:0] pulse_code = ctrl_cfg[fps_pkg::FLD_PULSE_LO +: 2];
    wire in_cfg = (state == fps_pkg::ST_NONVERIFY) || (state == fps_pkg::ST_LOW_HELD)
                  || (state == fps_pkg::ST_VERIFY);
    wire word_wr = ctrl_wr && ctrl_word; // R18
    wire ctrl_acc = word_wr && in_cfg;
    wire new_hold = ctrl_wdata[fps_pkg::BIT_HOLD];
    wire new_we = ctrl_wdata[fps_pkg::BIT_WE];
    wire trig_ok = flash_wr && in_cfg && we && !read_protect; // R3 R20
    wire erase_go = trig_ok && erase_sel && (flash_wdata == flash_addr); // R4
    wire word_go = trig_ok && !erase_sel && !dword_sel; // R21
    wire low_go = trig_ok && !erase_sel && dword_sel; // R6
    wire high_go = low_go && (state == fps_pkg::ST_LOW_HELD) && (flash_addr == pulse_addr); // R9
    wire launch = (next_state == fps_pkg::ST_BUSY) && (state != fps_pkg::ST_BUSY);
    wire busy_now = (state == fps_pkg::ST_BUSY);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        case (state)
            fps_pkg::ST_STANDARD:
                if (word_wr)
                    next_state = fps_pkg::ST_UNLOCKED; // R1
            fps_pkg::ST_UNLOCKED:
                if (flash_wr)
                    next_state = (flash_wdata == flash_addr) ? fps_pkg::ST_SETTLE
                                 : fps_pkg::ST_STANDARD; // R1
            fps_pkg::ST_SETTLE:
                if (settle_cnt == 8'h00)
                    next_state = fps_pkg::ST_NONVERIFY; // R1
            fps_pkg::ST_NONVERIFY, fps_pkg::ST_LOW_HELD, fps_pkg::ST_VERIFY:
                if (ctrl_acc)
                begin
                    if (!new_hold)
                        next_state = fps_pkg::ST_STANDARD; // R17
                    else if (state == fps_pkg::ST_VERIFY && !new_we)
                        next_state = fps_pkg::ST_NONVERIFY; // R16
                    else if (state == fps_pkg::ST_LOW_HELD)
                        next_state = fps_pkg::ST_NONVERIFY; // R2
                end
                else if (erase_go || word_go || high_go)
                    next_state = fps_pkg::ST_BUSY; // R9 R21
                else if (low_go)
                    next_state = fps_pkg::ST_LOW_HELD; // R9
            fps_pkg::ST_BUSY:
                if (timer_done)
                    next_state = fps_pkg::ST_VERIFY; // R11
            default:
                next_state = fps_pkg::ST_STANDARD;
        endcase
    end

    // ------------------------------------------------------------
    // State, unlock wait, control register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            state <= fps_pkg::ST_STANDARD;
            settle_cnt <= 8'h00;
            ctrl_cfg <= fps_pkg::CTRL_RESET;
        end
        else
        begin
            state <= next_state;
            if (next_state == fps_pkg::ST_SETTLE && state != fps_pkg::ST_SETTLE)
                settle_cnt <= 8'(fps_pkg::UNLOCK_CYCLES - 1); // R1
            else if (settle_cnt != 8'h00)
                settle_cnt <= settle_cnt - 8'h01;
            if (ctrl_acc)
                ctrl_cfg <= ctrl_wdata & fps_pkg::CTRL_WMASK; // R2 R7
            else if (state == fps_pkg::ST_SETTLE && next_state == fps_pkg::ST_NONVERIFY)
                ctrl_cfg <= ctrl_cfg | fps_pkg::HOLD_MASK; // R7
        end
    end

    // ------------------------------------------------------------
    // Supply margin sync and fault flag
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            vs1 <= 1'b0;
            vs2 <= 1'b0;
            vs3 <= 1'b0;
            vpp_ok <= 1'b0;
            fault <= 1'b0;
        end
        else
        begin
            vs1 <= vpp_in;
            vs2 <= vs1;
            vs3 <= vs2;
            if (vs2 == vs3)
                vpp_ok <= vs3; // R8
            fault <= (busy_now && !vpp_ok)
                     || (fault && !(ctrl_acc && !ctrl_wdata[fps_pkg::BIT_FAULT])); // R12
        end
    end

    // ------------------------------------------------------------
    // Outputs and pulse capture
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            ctrl_rdata <= fps_pkg::CTRL_RESET;
            pulse_active <= 1'b0;
            pulse_erase <= 1'b0;
            pulse_dword <= 1'b0;
            pulse_addr <= 16'h0000;
            pulse_data <= 32'h0000_0000;
            writing_mode <= 1'b0;
            verify_mode <= 1'b0;
        end
        else
        begin
            ctrl_rdata <= ctrl_cfg | (16'(vpp_ok) << fps_pkg::BIT_VPP)
                          | (16'(fault) << fps_pkg::BIT_FAULT)
                          | (16'(busy_now) << fps_pkg::BIT_BUSY); // R8 R10 R12
            pulse_active <= (next_state == fps_pkg::ST_BUSY); // R10
            writing_mode <= (next_state != fps_pkg::ST_STANDARD)
                            && (next_state != fps_pkg::ST_UNLOCKED)
                            && (next_state != fps_pkg::ST_SETTLE); // R7
            verify_mode <= (next_state == fps_pkg::ST_VERIFY); // R11
            if (launch)
            begin
                pulse_erase <= erase_sel;
                pulse_dword <= high_go;
            end
            if (high_go)
                pulse_data[31:16] <= flash_wdata; // R9
            else if (launch || (low_go && next_state == fps_pkg::ST_LOW_HELD))
            begin
                pulse_addr <= flash_addr;
                pulse_data <= {16'h0000, flash_wdata};
            end
        end
    end

    fps_pulse_timer #(
        .LONG2_CYCLES(PULSE2_CYCLES),
        .LONG3_CYCLES(PULSE3_CYCLES)
    ) u_timer (
        .clk_sys(clk_sys),
        .reset(reset),
        .start(launch),
        .width_code(pulse_code),
        .running(timer_running),
        .done(timer_done)
    );

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    localparam int UW = fps_pkg::UNLOCK_CYCLES;
    localparam int UW1 = fps_pkg::UNLOCK_CYCLES + 1;
    logic [16:0] busy_len;
    wire [16:0] exp_len = (pulse_code == 2'h0) ? 17'(fps_pkg::PULSE0_CYCLES) :
                          (pulse_code == 2'h1) ? 17'(fps_pkg::PULSE1_CYCLES) :
                          (pulse_code == 2'h2) ? 17'(PULSE2_CYCLES) : 17'(PULSE3_CYCLES);

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            busy_len <= 17'h0_0000;
        else
            busy_len <= pulse_active ? busy_len + 17'h0_0001 : 17'h0_0000;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence s_unlock;
        state == fps_pkg::ST_UNLOCKED && flash_wr && flash_wdata == flash_addr;
    endsequence
    sequence s_high;
        high_go && !ctrl_acc;
    endsequence

    a_unlock_wait: assert property (s_unlock |=> !writing_mode ##[UW:UW1] writing_mode) // R1
        else $error("writing mode not entered after unlock wait");
    a_cfg_no_pulse: assert property ($rose(pulse_active) |-> $past(flash_wr)) // R2
        else $error("pulse started without flash write");
    a_we_gate: assert property ($rose(pulse_active) |-> $past(we) && !$past(read_protect)) // R3
        else $error("pulse started while disabled or protected"); // R20
    a_erase_select: assert property ($rose(pulse_active) |-> pulse_erase == $past(erase_sel)) // R4
        else $error("pulse kind does not follow erase select");
    a_pulse_width: assert property ($fell(pulse_active) |-> busy_len == exp_len) // R5
        else $error("pulse length wrong for width code");
    a_dword_pair: assert property (s_high |=> pulse_active && pulse_dword
        && pulse_data[31:16] == $past(flash_wdata) && pulse_addr == $past(flash_addr)) // R9
        else $error("doubleword not launched on second write");
    a_busy_flag: assert property (ctrl_rdata[fps_pkg::BIT_BUSY] == $past(pulse_active)) // R10
        else $error("busy flag does not track pulse");
    a_verify_entry: assert property ($fell(pulse_active) |-> verify_mode && writing_mode) // R11
        else $error("verify mode not entered after pulse");
    a_fault_set: assert property (busy_now && !vpp_ok |=> ##1 ctrl_rdata[fps_pkg::BIT_FAULT]) // R12
        else $error("supply fault not flagged");
    a_vpp_status: assert property (ctrl_rdata[fps_pkg::BIT_VPP] == $past(vpp_ok)) // R8
        else $error("supply margin bit wrong");
    a_we_exit: assert property (state == fps_pkg::ST_VERIFY && ctrl_acc && !new_we && new_hold
        |=> !verify_mode && writing_mode) // R16
        else $error("clearing write enable did not leave verify");
    a_hold_exit: assert property (ctrl_acc && !new_hold |=> !writing_mode) // R17
        else $error("clearing hold bit did not leave writing mode");
    a_hold_keep: assert property (writing_mode && !(ctrl_acc && !new_hold) |=> writing_mode) // R7
        else $error("writing mode lost while hold set");
    a_byte_ignored: assert property (ctrl_wr && !ctrl_word && state != fps_pkg::ST_SETTLE
        && !flash_wr && !timer_done |=> $stable(ctrl_cfg) && state == $past(state)) // R18
        else $error("byte access changed control register");
    a_word_start: assert property (word_go && !ctrl_acc |=> pulse_active && !pulse_dword
        && pulse_data[15:0] == $past(flash_wdata)) // R21
        else $error("single word write did not start pulse");
    a_timer_busy: assert property (timer_running == busy_now) // R22
        else $error("pulse timer out of step with busy state");

endmodule : fps_sequencer

`default_nettype wire

/* File: hw/fps_pkg.sv */
`default_nettype none

package fps_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int UNLOCK_WAIT_NS = 10000;
    localparam int UNLOCK_CYCLES = (UNLOCK_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE0_NS = 51200;
    localparam int PULSE1_NS = 102400;
    localparam int PULSE2_NS = 1638400;
    localparam int PULSE3_NS = 10000000;
    localparam int PULSE0_CYCLES = PULSE0_NS / CLK_PERIOD_NS;
    localparam int PULSE1_CYCLES = PULSE1_NS / CLK_PERIOD_NS;
    localparam int PULSE2_CYCLES = PULSE2_NS / CLK_PERIOD_NS;
    localparam int PULSE3_CYCLES = PULSE3_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Control register layout
    // ------------------------------------------------------------
    localparam int BIT_WE = 0;
    localparam int BIT_ERASE = 1;
    localparam int BIT_BUSY = 2;
    localparam int BIT_FAULT = 3;
    localparam int BIT_VPP = 4;
    localparam int FLD_PULSE_LO = 5;
    localparam int BIT_WIDTH = 7;
    localparam int BIT_HOLD = 15;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] CTRL_WMASK = 16'h80E3;
    localparam logic [15:0] HOLD_MASK = 16'h8000;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_STANDARD,
        ST_UNLOCKED,
        ST_SETTLE,
        ST_NONVERIFY,
        ST_LOW_HELD,
        ST_BUSY,
        ST_VERIFY
    } fps_state_t;

endpackage : fps_pkg

`default_nettype wire

/* File: hw/fps_pulse_timer.sv */
`default_nettype none

module fps_pulse_timer #(
    parameter int unsigned LONG2_CYCLES = fps_pkg::PULSE2_CYCLES,
    parameter int unsigned LONG3_CYCLES = fps_pkg::PULSE3_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Control
    input wire logic start,
    input wire logic [1:0] width_code,
    // Status
    output logic running,
    output logic done
);

    logic [16:0] count;
    wire [16:0] load_value;

    // ------------------------------------------------------------
    // Pulse length lookup
    // ------------------------------------------------------------
    assign load_value = (width_code == 2'h0) ? 17'(fps_pkg::PULSE0_CYCLES - 1) :
                        (width_code == 2'h1) ? 17'(fps_pkg::PULSE1_CYCLES - 1) : // R5
                        (width_code == 2'h2) ? 17'(LONG2_CYCLES - 1) :
                        17'(LONG3_CYCLES - 1);
    assign done = running && (count == 17'h0_0000); // R22

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            running <= 1'b0;
            count <= 17'h0_0000;
        end
        else if (start)
        begin
            running <= 1'b1;
            count <= load_value;
        end
        else if (done)
        begin
            running <= 1'b0;
        end
        else if (running)
        begin
            count <= count - 17'h0_0001; // R22
        end
    end

endmodule : fps_pulse_timer

`default_nettype wire

/* File: test/fps_testbench.sv */
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------
    // Clock, signals and design
    // ----------------------------------------
    localparam int P2 = 20;
    localparam int P3 = 30;
    localparam int LENS [4] = '{512, 1024, P2, P3};
    localparam int VERIFY_GAP = 40;
    localparam int MAX_PROGRAM_ATTEMPTS = 25;
    typedef struct {
        logic [15:0] addr;
        logic [31:0] data;
        logic dw;
        logic er;
        int len;
    } fps_note_t;
    logic clk_sys = 1'b0;
    logic reset, ctrl_wr, ctrl_word, flash_wr, vpp_in, read_protect;
    logic [15:0] ctrl_wdata, flash_addr, flash_wdata, ctrl_rdata, pulse_addr;
    logic [31:0] pulse_data;
    logic pulse_active, pulse_erase, pulse_dword, writing_mode, verify_mode;
    int n_mismatch = 0;
    int samples_checked = 0;
    int plen = 0;
    fps_note_t got;
    fps_note_t notes [$];

    always #50 clk_sys = ~clk_sys;

    fps_sequencer #(.PULSE2_CYCLES(P2), .PULSE3_CYCLES(P3)) dut (
        .clk_sys(clk_sys), .reset(reset), .ctrl_wr(ctrl_wr), .ctrl_word(ctrl_word),
        .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata), .flash_wr(flash_wr),
        .flash_addr(flash_addr), .flash_wdata(flash_wdata), .vpp_in(vpp_in),
        .read_protect(read_protect), .pulse_active(pulse_active), .pulse_erase(pulse_erase),
        .pulse_dword(pulse_dword), .pulse_addr(pulse_addr), .pulse_data(pulse_data),
        .writing_mode(writing_mode), .verify_mode(verify_mode)
    );

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        samples_checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[ERR] %0t %s: got %h expected %h", $time, m, g, e);
        end
    endtask : chk

    task automatic finish_test();
        $display("Counts: %0d checked, %0d mismatched", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #10;
    endtask : cyc

    task automatic ctrl_write(input logic [15:0] w, input logic word);
        ctrl_wr = 1'b1;
        ctrl_word = word;
        ctrl_wdata = w;
        cyc(1);
        ctrl_wr = 1'b0;
        cyc(1);
    endtask : ctrl_write

    task automatic flash_write(input logic [15:0] a, input logic [15:0] d);
        flash_wr = 1'b1;
        flash_addr = a;
        flash_wdata = d;
        cyc(1);
        flash_wr = 1'b0;
    endtask : flash_write

    task automatic prog(input logic [15:0] a, input logic [31:0] d, input logic dw,
                        input logic er, input int len);
        int n;
        n = 0;
        notes.push_back('{a, dw ? d : {16'h0000, d[15:0]}, dw, er, len});
        flash_wr = 1'b1;
        flash_addr = a;
        flash_wdata = d[15:0];
        cyc(1);
        if (dw)
        begin
            flash_wdata = d[31:16];
            cyc(1);
        end
        flash_wr = 1'b0;
        cyc(4);
        chk(32'(ctrl_rdata[2]), 32'h0000_0001, "busy during pulse");
        while (verify_mode !== 1'b1 && n < len + 20)
        begin
            cyc(1);
            n++;
        end
        if (verify_mode !== 1'b1)
        begin
            n_mismatch++;
            $display("[ERR] %0t pulse never ended", $time);
            finish_test();
        end
        cyc(2);
        chk(32'(ctrl_rdata[2]), 32'h0000_0000, "busy after pulse");
        cyc(VERIFY_GAP);
        chk(32'(verify_mode), 32'h0000_0001, "verify stands for double read");
    endtask : prog

    task automatic chk_pulse(input fps_note_t g);
        fps_note_t e;
        if (notes.size() == 0)
        begin
            chk(32'h0000_0001, 32'h0000_0000, "unexpected pulse");
            return;
        end
        e = notes.pop_front();
        chk(32'(g.addr), 32'(e.addr), "pulse address");
        chk(g.dw ? g.data : {16'h0000, g.data[15:0]}, e.data, "pulse data");
        chk(32'(g.dw), 32'(e.dw), "doubleword flag");
        chk(32'(g.er), 32'(e.er), "erase flag");
        chk(32'(g.len), 32'(e.len), "pulse length");
        chk(32'(verify_mode), 32'h0000_0001, "verify entry");
    endtask : chk_pulse

    task automatic done_test(input string s);
        $display("Test %s done", s);
    endtask : done_test

    // ----------------------------------------
    // Pulse monitor
    // ----------------------------------------
    always @(negedge clk_sys)
    begin
        if (pulse_active === 1'b1)
        begin
            if (plen == 0)
                got = '{pulse_addr, pulse_data, pulse_dword, pulse_erase, 0};
            plen++;
        end
        else if (plen > 0)
        begin
            got.len = plen;
            plen = 0;
            chk_pulse(got);
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        logic [15:0] a;
        int c;
        logic [31:0] d;
        reset = 1'b1;
        ctrl_wr = 1'b0;
        ctrl_word = 1'b0;
        ctrl_wdata = 16'h0000;
        flash_wr = 1'b0;
        flash_addr = 16'h0000;
        flash_wdata = 16'h0000;
        vpp_in = 1'b1;
        read_protect = 1'b0;
        void'($urandom(32'hd52a));
        repeat (8) @(posedge clk_sys);
        #10;
        chk(32'(ctrl_rdata), 32'h0000_0000, "reset value");
        reset = 1'b0;
        a = 16'($urandom);
        ctrl_write(a, 1'b1);
        flash_write(a, a);
        c = 0;
        while (writing_mode !== 1'b1 && c < 200)
        begin
            cyc(1);
            c++;
        end
        if (writing_mode !== 1'b1)
        begin
            n_mismatch++;
            $display("[ERR] %0t writing mode never entered", $time);
            finish_test();
        end
        chk(32'(c), 32'(fps_pkg::UNLOCK_CYCLES), "unlock settle");
        cyc(2);
        chk(32'(ctrl_rdata), 32'h0000_8010, "hold after unlock");
        done_test("unlock");
        ctrl_write(16'h80A1, 1'b0);
        cyc(2);
        chk(32'(ctrl_rdata), 32'h0000_8010, "byte access");
        ctrl_write(16'h80A1, 1'b1);
        cyc(2);
        chk(32'(ctrl_rdata), 32'h0000_80B1, "mode fields");
        chk(32'(pulse_active), 32'h0000_0000, "no pulse from config");
        a = 16'($urandom) & 16'hFFFE;
        d = $urandom;
        for (c = 0; c < 2 && c < MAX_PROGRAM_ATTEMPTS; c++)
        begin
            prog(a, d, 1'b1, 1'b0, 1024);
        end
        done_test("doubleword");
        for (c = 0; c < 4; c++)
        begin
            ctrl_write(16'h8001 | (16'(c) << 5), 1'b1);
            if (c == 3)
                vpp_in = 1'b0;
            prog(16'($urandom), $urandom, 1'b0, 1'b0, LENS[c]);
        end
        chk(32'(ctrl_rdata), 32'h0000_8069, "supply fault");
        vpp_in = 1'b1;
        cyc(6);
        ctrl_write(16'h8001, 1'b1);
        cyc(2);
        chk(32'(ctrl_rdata), 32'h0000_8011, "fault cleared");
        done_test("codes");
        ctrl_write(16'h8020, 1'b1);
        cyc(2);
        chk(32'({verify_mode, writing_mode}), 32'h0000_0001, "non-verify");
        flash_write(16'($urandom), 16'($urandom));
        cyc(1);
        ctrl_write(16'h8001, 1'b1);
        read_protect = 1'b1;
        flash_write(16'($urandom), 16'($urandom));
        cyc(1);
        read_protect = 1'b0;
        cyc(3);
        chk(32'(pulse_active), 32'h0000_0000, "refused write");
        done_test("refusals");
        ctrl_write(16'h80C3, 1'b1);
        a = 16'($urandom);
        flash_write(a, ~a);
        cyc(2);
        chk(32'(pulse_active), 32'h0000_0000, "erase key");
        prog(a, {16'h0000, a}, 1'b0, 1'b1, P2);
        done_test("erase");
        ctrl_write(16'h0000, 1'b1);
        cyc(2);
        chk(32'({verify_mode, writing_mode}), 32'h0000_0000, "standard");
        chk(32'(ctrl_rdata), 32'h0000_0010, "standard value");
        chk(32'(notes.size()), 32'h0000_0000, "pulses seen");
        done_test("exit");
        finish_test();
    end
endmodule : testbench

`default_nettype wire
